// ---- verilog/fwd_pkg.sv ----
// Shared constants and types of the stream forwarding engine.
// Assumes a 10 MHz core clock and a local register strobe port.
`default_nettype none

package fwd_pkg;
  localparam int NPORT = 4;
  localparam int NTX   = 2;
  // Register offsets and reset values
  localparam logic [7:0] ADDR_ROUTE = 8'h20;
  localparam logic [7:0] ADDR_MODE  = 8'h21;
  localparam logic [7:0] ADDR_STAT  = 8'h22;
  localparam logic [7:0] ROUTE_RST  = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'hC0;
  // Field positions
  localparam int DIS_LSB  = 0; // route: per-port disable
  localparam int MAP_LSB  = 4; // route: buffer to transmitter map
  localparam int SYNC_LSB = 2; // mode: 2 bits per transmitter
  localparam int RR_LSB   = 6; // mode: 1 bit per transmitter
  localparam int SYNCD_LSB = 0; // status: synchronized
  localparam int LOST_LSB  = 2; // status: lost sync, read clears
  // Timing
  localparam int CLK_NS       = 100;
  localparam int SYNC_WAIT_NS = 100000;
  localparam int SYNC_WAIT_CYC = SYNC_WAIT_NS / CLK_NS;
  localparam int TMR_W = $clog2(SYNC_WAIT_CYC + 1);

  typedef enum logic [1:0] {
    PK_FS    = 2'h0,
    PK_FE    = 2'h1,
    PK_LINE  = 2'h2,
    PK_OTHER = 2'h3
  } pkt_kind_t;

  typedef enum logic [1:0] {
    SY_OFF    = 2'h0,
    SY_BASIC  = 2'h1,
    SY_ILEAVE = 2'h2,
    SY_CONCAT = 2'h3
  } sync_var_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1,
    ST_HUNT = 2'h3,
    ST_DROP = 2'h2
  } eng_st_t;

  typedef struct packed {
    pkt_kind_t  kind;
    logic [1:0] vc;
    logic [7:0] data;
    logic       last;
  } vword_t;
endpackage : fwd_pkg

`default_nettype wire

// ---- verilog/csi2_stream_forwarding_engine.sv ----
// Forwarding engine: four video buffers to two CSI-2 transmitters.
// Buffers and register strobes share clk; link clocks come from outside.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Top: registers, buffer routing, two engines, link side per transmitter

module csi2_stream_forwarding_engine #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // Register strobes
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic [7:0]                 reg_rdata,
  // Video buffers
  input  wire logic [3:0]            buf_pkt_avail,
  input  wire logic [3:0]            buf_data_avail,
  input  wire fwd_pkg::vword_t [3:0] buf_word,
  output logic [3:0]                 buf_pop,
  // CSI-2 transmit side
  input  wire logic [1:0]            lnk_clk,
  output logic [1:0]                 tx_valid,
  output fwd_pkg::vword_t [1:0]      tx_word,
  output logic [1:0]                 tx_hs
);
  typedef struct packed {
    logic [7:0]                 route;
    logic [7:0]                 mode;
    logic [7:0]                 rdata;
    logic [1:0]                 lost;
    logic [1:0]                 lk1;
    logic [1:0]                 lk2;
    logic [1:0]                 lk3;
    logic [1:0]                 val;
    logic [1:0]                 hs;
    fwd_pkg::vword_t [1:0]      word;
  } top_t;
  top_t s_ff, nxt_s;

  logic [1:0][3:0]        eng_pop;
  logic [1:0]             eng_push, eng_ready, f_valid, edge_r, syncd, lost_evt;
  fwd_pkg::vword_t [1:0]  eng_word, f_word;
  logic [1:0][3:0]        elig;

  // Link clock edges seen after two synchroniser stages
  assign edge_r = s_ff.lk2 & ~s_ff.lk3;

  for (genvar t = 0; t < 2; t++) begin : g_tx
    // Buffer belongs here when its map bit names this transmitter and its disable bit is clear
    for (genvar i = 0; i < 4; i++) begin : g_map
      assign elig[t][i] = (s_ff.route[fwd_pkg::MAP_LSB+i] == 1'(t)) &
                          ~s_ff.route[fwd_pkg::DIS_LSB+i];
    end
    fwd_engine i_fwd_engine (
      .clk       (clk),
      .arst_n    (arst_n),
      .elig      (elig[t]),
      .rr_en     (s_ff.mode[fwd_pkg::RR_LSB+t]),
      .sync_var  (fwd_pkg::sync_var_t'(s_ff.mode[fwd_pkg::SYNC_LSB+2*t +: 2])),
      .pkt_avail (buf_pkt_avail),
      .data_avail(buf_data_avail),
      .bword     (buf_word),
      .pop       (eng_pop[t]),
      .push      (eng_push[t]),
      .push_ready(eng_ready[t]),
      .push_word (eng_word[t]),
      .synced    (syncd[t]),
      .lost_evt  (lost_evt[t])
    );
    fwd_fifo #(.W($bits(fwd_pkg::vword_t)), .DEPTH(FIFO_DEPTH)) i_fwd_fifo (
      .clk      (clk),
      .arst_n   (arst_n),
      .in_valid (eng_push[t]),
      .in_ready (eng_ready[t]),
      .in_data  (eng_word[t]),
      .out_valid(f_valid[t]),
      .out_ready(edge_r[t]),
      .out_data (f_word[t])
    );
  end

  // Each buffer is mapped to one engine, so pops never collide
  assign buf_pop   = eng_pop[0] | eng_pop[1];
  assign reg_rdata = s_ff.rdata;
  assign tx_valid  = s_ff.val;
  assign tx_word   = s_ff.word;
  assign tx_hs     = s_ff.hs;

  // Registers, sticky loss flags, link side
  always_comb begin
    nxt_s     = s_ff;
    nxt_s.lk1 = lnk_clk;
    nxt_s.lk2 = s_ff.lk1;
    nxt_s.lk3 = s_ff.lk2;
    if (reg_wr) begin
      if (reg_addr == fwd_pkg::ADDR_ROUTE) nxt_s.route = reg_wdata;
      else if (reg_addr == fwd_pkg::ADDR_MODE) nxt_s.mode = reg_wdata;
    end
    if (reg_rd) begin
      if (reg_addr == fwd_pkg::ADDR_ROUTE) nxt_s.rdata = s_ff.route;
      else if (reg_addr == fwd_pkg::ADDR_MODE) nxt_s.rdata = s_ff.mode;
      else if (reg_addr == fwd_pkg::ADDR_STAT) begin
        nxt_s.rdata = '0;
        nxt_s.rdata[fwd_pkg::SYNCD_LSB +: 2] = syncd;
        nxt_s.rdata[fwd_pkg::LOST_LSB +: 2]  = s_ff.lost;
        nxt_s.lost  = '0;
      end else nxt_s.rdata = '0;
    end
    nxt_s.lost = nxt_s.lost | lost_evt;
    // One word per link clock rising edge; HS while data waits
    for (int t = 0; t < 2; t++) begin
      if (edge_r[t]) begin
        nxt_s.val[t]  = f_valid[t];
        nxt_s.word[t] = f_word[t];
      end
      nxt_s.hs[t] = f_valid[t] | eng_push[t] | nxt_s.val[t];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff       <= '0;
      s_ff.route <= fwd_pkg::ROUTE_RST;
      s_ff.mode  <= fwd_pkg::MODE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  lost_sticky_a: assert property (lost_evt[0] |=> s_ff.lost[0])
    else $error("lost flag not set");
  lost_clear_a: assert property (reg_rd && reg_addr == fwd_pkg::ADDR_STAT && lost_evt == 2'h0
    |=> s_ff.lost == 2'h0 && s_ff.rdata[fwd_pkg::LOST_LSB +: 2] == $past(s_ff.lost))
    else $error("status read did not clear");
  one_owner_a: assert property ((eng_pop[0] & eng_pop[1]) == 4'h0)
    else $error("two engines popped one buffer");
  link_step_a: assert property (edge_r == 2'h0 |=> $stable(s_ff.word))
    else $error("link word changed off edge");
  hs_data_a: assert property (s_ff.val[1] |-> s_ff.hs[1])
    else $error("valid word outside high speed");
  full_c: cover property (!eng_ready[0]);
endmodule : csi2_stream_forwarding_engine

////////////////////////////////////////////////////////////////////////
// Word FIFO between an engine and its link side
module fwd_fifo #(
  parameter int W     = 13,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } fifo_st_t;
  fifo_st_t s_ff, nxt_s;
  logic     wr, rd;

  // Full and empty straight from the count
  assign in_ready  = (s_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_ff.cnt != '0);
  assign out_data  = s_ff.mem[s_ff.rp];
  assign wr        = in_valid & in_ready;
  assign rd        = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    nxt_s = s_ff;
    if (wr) begin
      nxt_s.mem[s_ff.wp] = in_data;
      nxt_s.wp = AW'((s_ff.wp + 1'b1) % DEPTH);
    end
    if (rd) begin
      nxt_s.rp = AW'((s_ff.rp + 1'b1) % DEPTH);
    end
    nxt_s.cnt = s_ff.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) s_ff <= '0;
    else         s_ff <= nxt_s;
  end
endmodule : fwd_fifo

////////////////////////////////////////////////////////////////////////
// One engine per transmitter, fully independent of the other
module fwd_engine (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  // Configuration
  input  wire logic [3:0]                  elig,
  input  wire logic                        rr_en,
  input  wire fwd_pkg::sync_var_t          sync_var,
  // Video buffers
  input  wire logic [3:0]                  pkt_avail,
  input  wire logic [3:0]                  data_avail,
  input  wire fwd_pkg::vword_t [3:0]       bword,
  output logic [3:0]                       pop,
  // FIFO fill side
  output logic                             push,
  input  wire logic                        push_ready,
  output fwd_pkg::vword_t                  push_word,
  // Status
  output logic                             synced,
  output logic                             lost_evt
);
  typedef struct packed {
    fwd_pkg::eng_st_t          st;
    logic [1:0]                cur;
    logic                      busy;
    logic                      drop;
    fwd_pkg::pkt_kind_t        kind_exp;
    logic                      synced;
    logic                      lost;
    logic [fwd_pkg::TMR_W-1:0] tmr;
  } eng_t;
  eng_t s_ff, nxt_s;

  logic [3:0] fs_head;
  logic [3:0] ready;
  logic [3:0] bad;
  logic [1:0] low, rr_pick, nxt_cam, bad_idx;
  logic       mode_sync, leader, all_fs;
  fwd_pkg::vword_t head;

  // Per-buffer packet and data readiness
  for (genvar i = 0; i < 4; i++) begin : g_port
    assign ready[i]   = pkt_avail[i] & data_avail[i] & elig[i];
    assign fs_head[i] = (bword[i].kind == fwd_pkg::PK_FS);
    assign bad[i]     = ready[i] & ~fs_head[i];
  end

  // Cyclic search for the next set bit after a start index
  function automatic logic [1:0] next_set(input logic [1:0] start, input logic [3:0] m);
    logic [1:0] idx;
    next_set = start;
    for (int k = 4; k >= 1; k--) begin
      idx = 2'(start + 2'(k));
      if (m[idx]) next_set = idx;
    end
  endfunction : next_set

  assign mode_sync = (sync_var != fwd_pkg::SY_OFF);
  assign low       = next_set(2'h3, elig);
  assign rr_pick   = next_set(s_ff.cur, ready);
  assign nxt_cam   = next_set(s_ff.cur, elig);
  assign bad_idx   = next_set(2'h3, bad);
  assign all_fs    = (elig != '0) && ((~elig | (ready & fs_head)) == 4'hF);
  assign head      = bword[s_ff.cur];
  assign leader    = (s_ff.cur == low);
  assign synced    = s_ff.synced;
  assign lost_evt  = s_ff.lost;

  // Sequencing: selection, packet move, sync hunt and loss
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.lost = 1'b0;
    pop        = '0;
    push       = 1'b0;
    push_word  = head;
    case (s_ff.st)
      fwd_pkg::ST_IDLE: begin
        nxt_s.synced = 1'b0;
        if (mode_sync) begin
          nxt_s.st = fwd_pkg::ST_HUNT;
        end else if (rr_en && ready != '0) begin
          nxt_s.cur = rr_pick;
          nxt_s.st  = fwd_pkg::ST_SEND;
        end
      end
      fwd_pkg::ST_HUNT: begin
        // Discard until every source shows a frame start
        if (!mode_sync) begin
          nxt_s.st = fwd_pkg::ST_IDLE;
        end else if (all_fs) begin
          nxt_s.synced = 1'b1;
          nxt_s.cur    = low;
          nxt_s.tmr    = '0;
          nxt_s.st     = fwd_pkg::ST_SEND;
        end else if (bad != '0) begin
          nxt_s.cur = bad_idx;
          nxt_s.st  = fwd_pkg::ST_DROP;
        end
      end
      fwd_pkg::ST_DROP: begin
        if (data_avail[s_ff.cur]) begin
          pop[s_ff.cur] = 1'b1;
          if (head.last) nxt_s.st = fwd_pkg::ST_HUNT;
        end
      end
      default: begin // ST_SEND
        if (!s_ff.busy) begin
          nxt_s.tmr = s_ff.tmr + 1'b1;
          if (!mode_sync && !rr_en) begin
            nxt_s.st = fwd_pkg::ST_IDLE;
          end else if (mode_sync && ready[s_ff.cur]) begin
            // Later cameras must match the leader's packet kind
            if (!leader && head.kind != s_ff.kind_exp) begin
              nxt_s.lost = 1'b1;
            end else begin
              nxt_s.busy = 1'b1;
              nxt_s.tmr  = '0;
              if (leader) nxt_s.kind_exp = head.kind;
              // Interleave and concatenation keep only the first camera's FS and FE
              nxt_s.drop = (sync_var != fwd_pkg::SY_BASIC) && !leader &&
                           (head.kind == fwd_pkg::PK_FS || head.kind == fwd_pkg::PK_FE);
            end
          end else if (mode_sync && s_ff.tmr == fwd_pkg::TMR_W'(fwd_pkg::SYNC_WAIT_CYC - 1)) begin
            nxt_s.lost = 1'b1;
          end else if (!mode_sync && ready[s_ff.cur]) begin
            nxt_s.busy = 1'b1;
            nxt_s.drop = 1'b0;
          end
        end else if (data_avail[s_ff.cur] && (s_ff.drop || push_ready)) begin
          pop[s_ff.cur] = 1'b1;
          push          = !s_ff.drop;
          if (head.last) begin
            nxt_s.busy = 1'b0;
            nxt_s.cur  = mode_sync ? nxt_cam : s_ff.cur;
            if (!mode_sync) nxt_s.st = fwd_pkg::ST_IDLE;
          end
        end
        if (nxt_s.lost) begin
          nxt_s.synced = 1'b0;
          nxt_s.busy   = 1'b0;
          nxt_s.st     = fwd_pkg::ST_HUNT;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) s_ff <= '0;
    else         s_ff <= nxt_s;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Checks
  dis_port_a: assert property ((pop & ~elig) == 4'h0)
    else $error("pop from a disabled or unmapped buffer");
  pop_data_a: assert property (pop != 4'h0 |-> data_avail[s_ff.cur])
    else $error("pop without data available");
  rr_gate_a: assert property (push && !mode_sync |-> rr_en)
    else $error("round robin push while disabled");
  no_unsync_a: assert property (push && mode_sync |-> s_ff.synced)
    else $error("push while not synchronized");
  lost_hunt_a: assert property (s_ff.lost |-> s_ff.st == fwd_pkg::ST_HUNT && !s_ff.synced)
    else $error("lost sync without returning to hunt");
  lock_fs_a: assert property ($rose(s_ff.synced) |-> ##[1:300] (s_ff.busy && s_ff.kind_exp == fwd_pkg::PK_FS)
    or ##[1:300] !s_ff.synced)
    else $error("sync round did not open with frame start");
  vc_keep_a: assert property (push |-> push_word.vc == bword[s_ff.cur].vc)
    else $error("forwarded packet lost its channel");
  rr_order_a: assert property (s_ff.st == fwd_pkg::ST_IDLE && !mode_sync && rr_en && ready != 4'h0
    |=> s_ff.cur == $past(rr_pick))
    else $error("round robin picked wrong port");
  rr_c: cover property (push && !mode_sync ##[1:50] push && !mode_sync);
  lock_c: cover property ($rose(s_ff.synced));
  lost_c: cover property (s_ff.lost);
endmodule : fwd_engine

`default_nettype wire

// ---- tb/csi2_rx_model.sv ----
// Receiving processor model: makes both link clocks and collects words.
// Assumes tx_word is steady across each link clock rising edge.
`timescale 1ns/1ps
`default_nettype none

module csi2_rx_model (
  // Link control
  input  wire logic                  run,
  output logic [1:0]                 lnk_clk,
  // Transmit side of the block
  input  wire logic [1:0]            tx_valid,
  input  wire fwd_pkg::vword_t [1:0] tx_word
);
  logic            l0 = 1'b0;
  logic            l1 = 1'b0;
  fwd_pkg::vword_t rxq [2][$];

  ////////////////////////////////////////////////////////////////////////
  // 800 ns links, held still between frames, phases unrelated to clk
  initial begin
    #137;
    forever #400 if (run) l0 = ~l0;
  end
  initial begin
    #263;
    forever #400 if (run) l1 = ~l1;
  end
  assign lnk_clk = {l1, l0};

  // Word of the previous period is taken at the next link edge
  always @(posedge l0) begin
    if (tx_valid[0]) rxq[0].push_back(tx_word[0]);
  end
  always @(posedge l1) begin
    if (tx_valid[1]) rxq[1].push_back(tx_word[1]);
  end
endmodule : csi2_rx_model

`default_nettype wire

// ---- tb/csi2_stream_forwarding_engine_tb.sv ----
// Bench of the forwarding engine: buffer models, registers, both links.
// Assumes fwd_pkg, the design and csi2_rx_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module csi2_stream_forwarding_engine_tb;
  logic                  clk;
  logic                  arst_n;
  logic                  reg_wr;
  logic                  reg_rd;
  logic                  run;
  logic [7:0]            reg_addr;
  logic [7:0]            reg_wdata;
  logic [7:0]            reg_rdata;
  logic [3:0]            buf_pkt_avail;
  logic [3:0]            buf_data_avail;
  logic [3:0]            buf_pop;
  logic [3:0]            pop_s;
  fwd_pkg::vword_t [3:0] buf_word;
  fwd_pkg::vword_t [1:0] tx_word;
  logic [1:0]            lnk_clk;
  logic [1:0]            tx_valid;
  logic [1:0]            tx_hs;
  fwd_pkg::vword_t       bq [4][$];
  fwd_pkg::vword_t       exq [$];
  int                    n_errors = 0;
  int                    tests_run = 0;

  csi2_stream_forwarding_engine #(.FIFO_DEPTH(16)) i_csi2_stream_forwarding_engine (
    .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .buf_pkt_avail(buf_pkt_avail),
    .buf_data_avail(buf_data_avail), .buf_word(buf_word), .buf_pop(buf_pop),
    .lnk_clk(lnk_clk), .tx_valid(tx_valid), .tx_word(tx_word), .tx_hs(tx_hs));
  csi2_rx_model i_csi2_rx_model (.run(run), .lnk_clk(lnk_clk), .tx_valid(tx_valid), .tx_word(tx_word));

  ////////////////////////////////////////////////////////////////////////
  // 10 MHz core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Buffers: pops taken at the last edge applied, then new heads shown;
  // an empty head alternates each cycle between inverted data and the stale word
  always @(negedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (pop_s[i] && bq[i].size() > 0) void'(bq[i].pop_front());
      buf_data_avail[i] = bq[i].size() > 0;
      buf_pkt_avail[i] = 1'b0;
      foreach (bq[i][k]) if (bq[i][k].last) buf_pkt_avail[i] = 1'b1;
      buf_word[i] = (bq[i].size() > 0) ? bq[i][0] : ~buf_word[i];
    end
    #10 pop_s = buf_pop;
  end

  task automatic check(string name, logic [12:0] seen, logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  // Read data holds until the next read, so it is taken a cycle late
  task automatic rd_chk(string n, logic [7:0] a, logic [7:0] m, logic [7:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    check(n, {5'h00, reg_rdata & m}, {5'h00, e});
  endtask : rd_chk

  // One packet of n words into buffer p, carrying that port's channel
  task automatic put(int p, fwd_pkg::pkt_kind_t k, int n, logic [3:0] id, bit ex);
    fwd_pkg::vword_t w;
    for (int j = 0; j < n; j++) begin
      w = '{k, p[1:0], {id, j[3:0]}, j == n - 1};
      bq[p].push_back(w);
      if (ex) exq.push_back(w);
    end
  endtask : put

  // Runs link t until the expected words arrive, then compares them
  task automatic drain(int t, string n);
    int c;
    c = 0;
    run = 1'b1;
    while (i_csi2_rx_model.rxq[t].size() < exq.size() && c < 5000) begin
      @(negedge clk);
      c++;
    end
    repeat (48) @(negedge clk);
    run = 1'b0;
    check(n, 13'(i_csi2_rx_model.rxq[t].size()), 13'(exq.size()));
    foreach (exq[i]) if (i < i_csi2_rx_model.rxq[t].size()) check(n, i_csi2_rx_model.rxq[t][i], exq[i]);
    check("hs idle", {11'h000, tx_hs}, 13'h0000);
    i_csi2_rx_model.rxq[t].delete();
    exq.delete();
  endtask : drain

  // Lines of two words; frame starts and ends are single words
  task automatic frame(bit all);
    for (int p = 0; p < 4; p++) put(p, fwd_pkg::PK_FS, 1, 4'h1, 1'b1);
    for (int l = 2; l < 4; l++) for (int p = 0; p < 4; p++) put(p, fwd_pkg::PK_LINE, 2, l[3:0], 1'b1);
    for (int p = 0; p < 4; p++) put(p, fwd_pkg::PK_FE, 1, 4'hF, all || p == 0);
    if (!all) exq = {exq[0], exq[4:$]};
  endtask : frame

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk("route rst", 8'h20, 8'hFF, 8'h00);
    rd_chk("mode rst", 8'h21, 8'hFF, 8'hC0);
    wr(8'h30, 8'h5A);
    rd_chk("unmapped", 8'h30, 8'hFF, 8'h00);
    rd_chk("status rst", 8'h22, 8'hFF, 8'h00);
    $display("test regs done");
  endtask : t_regs

  // Port 2 disabled, ports 1 and 3 mapped to the second transmitter
  task automatic t_rr();
    fwd_pkg::vword_t w;
    wr(8'h20, 8'hA4);
    rd_chk("route wr", 8'h20, 8'hFF, 8'hA4);
    put(2, fwd_pkg::PK_LINE, 2, 4'h2, 1'b0);
    put(0, fwd_pkg::PK_LINE, 3, 4'h0, 1'b1);
    w = bq[0].pop_back();
    repeat (20) @(negedge clk);
    check("partial held", 13'(bq[0].size()), 13'd2);
    bq[0].push_back(w);
    repeat (20) @(negedge clk);
    check("hs busy", {11'h000, tx_hs}, 13'h0001);
    drain(0, "rr tx0");
    check("tx1 quiet", 13'(i_csi2_rx_model.rxq[1].size()), 13'd0);
    check("disabled kept", 13'(bq[2].size()), 13'd2);
    for (int r = 0; r < 2; r++) for (int p = 1; p < 4; p += 2) put(p, fwd_pkg::PK_FS, 1, r[3:0], 1'b1);
    drain(1, "rr tx1");
    check("disabled kept", 13'(bq[2].size()), 13'd2);
    $display("test rr done");
  endtask : t_rr

  task automatic t_sync(logic [1:0] v);
    wr(8'h21, 8'h00);
    wr(8'h20, 8'h00);
    bq[2].delete();
    wr(8'h21, {4'h0, v, 2'h0});
    frame(v == 2'h1);
    drain(0, "sync frame");
    rd_chk("no loss", 8'h22, 8'h0C, 8'h00);
    $display("test sync %0d done", v);
  endtask : t_sync

  // Camera 3 stops after its frame start: loss, discard, then recovery
  task automatic t_loss();
    wr(8'h21, 8'h00);
    wr(8'h21, 8'h04);
    frame(1'b1);
    bq[3] = bq[3][0:0];
    exq.delete();
    run = 1'b1;
    repeat (1500) @(negedge clk);
    run = 1'b0;
    rd_chk("lost set", 8'h22, 8'h0D, 8'h04);
    rd_chk("lost clear", 8'h22, 8'h0C, 8'h00);
    check("discarded", 13'(bq[0].size()), 13'd0);
    i_csi2_rx_model.rxq[0].delete();
    frame(1'b1);
    drain(0, "resync");
    $display("test loss done");
  endtask : t_loss

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    #2000000;
    n_errors++;
    results();
  end

  initial begin
    {reg_wr, reg_rd, run, arst_n} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {buf_pkt_avail, buf_data_avail, pop_s} = 12'h000;
    buf_word = '0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    t_regs();
    t_rr();
    for (int v = 1; v < 4; v++) t_sync(v[1:0]);
    t_loss();
    results();
  end
endmodule : csi2_stream_forwarding_engine_tb

`default_nettype wire
